// ---- rtl/lke_defines.svh ----
// Constants for the legacy keyboard emulation block.
// Assumes inclusion by bare name from rtl/.
`ifndef LKE_DEFINES_SVH
`define LKE_DEFINES_SVH
`define LKE_OFF_CTRL    12'h100
`define LKE_OFF_INBUF   12'h104
`define LKE_OFF_OUTBUF  12'h108
`define LKE_OFF_STATUS  12'h10C
`define LKE_PORT_DATA   8'h60
`define LKE_PORT_CMD    8'h64
`define LKE_GA20_CMD    8'hD1
`define LKE_CTL_EE      0
`define LKE_CTL_EI      1
`define LKE_CTL_CP      2
`define LKE_CTL_INTERRUPT_REQUEST_ENABLE   3
`define LKE_CTL_EXTERNAL_INTERRUPT_ENABLE  4
`define LKE_CTL_GATE_A20_SEQUENCE_FLAG   5
`define LKE_CTL_KBA     6
`define LKE_CTL_MSA     7
`define LKE_CTL_A20S    8
`define LKE_CTL_MASK    32'h0000_01FD
`define LKE_ST_OUTFULL  0
`define LKE_ST_INFULL   1
`define LKE_ST_CMDDATA  3
`define LKE_ST_AUXFULL  5
`endif

// ---- rtl/lke_pkg.sv ----
// Types for the legacy keyboard emulation block.
// Assumes nothing of its surroundings.
package lke_pkg;
  typedef enum logic [1:0] {LKE_IO_IDLE, LKE_IO_RD, LKE_IO_WR} lke_io_t;
endpackage

// ---- rtl/lke_fifo.sv ----
// Synchronous valid/ready FIFO.
// Assumes one clock and active-low async reset.
`timescale 1ns/100ps
`default_nettype none
module lke_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;
  logic             valid_r, valid_nxt;
  logic [WIDTH-1:0] data_r, data_nxt;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = valid_r;
  assign out_data  = data_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt  = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    valid_nxt = (cnt_nxt != '0);
    // A word written into the slot about to be shown bypasses the array
    data_nxt  = (push && (wp_r == rp_nxt)) ? in_data : mem[rp_nxt];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      valid_r <= 1'b0;
      data_r  <= '0;
    end else begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      valid_r <= valid_nxt;
      data_r  <= data_nxt;
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/lke_top.sv ----
// Legacy keyboard/mouse controller emulation registers.
// Assumes a same-clock register port and a same-clock legacy I/O strobe port;
// external controller IRQ pins are asynchronous.
//
// How it works
// - Four registers at 100h, 104h, 108h, 10Ch.
// - Control register enables emulation, reports status.
// - IN 60h returns output buffer, clears output-full.
// - OUT 60h stores byte, sets input-full, clears cmd.
// - IN 64h returns status, no side effect.
// - OUT 64h stores byte, sets cmd, clears input-full.
// - D1h to 64h sets gate-A20 flag, else clears.
// - IRQ enable and output-full raise keyboard/mouse interrupt.
// - Character pending raises interrupt when output empties.
// - External enable passes external IRQs as emulation interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "lke_defines.svh"
module lke_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Operational register port
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // Legacy port I/O cycles
  input  wire logic        io_valid,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_port,
  input  wire logic [7:0]  io_wdata,
  output logic             io_claim,
  output logic      [7:0]  io_rdata,
  output logic             io_ready,
  // Input buffer byte stream toward emulation software
  output logic             inbyte_valid,
  output logic      [7:0]  inbyte_data,
  input  wire logic        inbyte_ready,
  // Interrupts
  input  wire logic        ext_kbd_irq,
  input  wire logic        ext_mouse_irq,
  output logic             keyboard_interrupt,
  output logic             mouse_interrupt,
  output logic             emulation_interrupt
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] inbuf_r, inbuf_nxt;
  logic [31:0] outbuf_r, outbuf_nxt;
  logic [31:0] stat_r, stat_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;
  logic [7:0]  iord_r, iord_nxt;
  logic        claim_r, claim_nxt, iordy_r, iordy_nxt;
  logic        kbi_r, kbi_nxt, msi_r, msi_nxt, emi_r, emi_nxt;
  logic [1:0]  kb_s_r, ms_s_r;
  lke_pkg::lke_io_t io_kind;
  logic        hit, fifo_in_ready, fifo_push;
  logic        out_full_fall;

  // ----------------------------------------
  // Legacy cycle decode
  // ----------------------------------------
  // The cycle after completion is the host's release, not a new request
  assign hit = io_valid && !iordy_r && ctrl_r[`LKE_CTL_EE]
    && (io_port == `LKE_PORT_DATA || io_port == `LKE_PORT_CMD);
  always_comb begin
    io_kind = lke_pkg::LKE_IO_IDLE;
    if (hit) begin
      io_kind = io_wr ? lke_pkg::LKE_IO_WR : lke_pkg::LKE_IO_RD;
    end
  end
  // Writes stall while the input stream is full
  assign fifo_push = (io_kind == lke_pkg::LKE_IO_WR) && fifo_in_ready;

  lke_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (io_wdata),
    .out_valid (inbyte_valid),
    .out_ready (inbyte_ready),
    .out_data  (inbyte_data)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    inbuf_nxt  = inbuf_r;
    outbuf_nxt = outbuf_r;
    stat_nxt   = stat_r;
    rdata_nxt  = 32'h0000_0000;
    ack_nxt    = 1'b0;
    iord_nxt   = iord_r;
    claim_nxt  = 1'b0;
    iordy_nxt  = 1'b0;
    if (reg_sel) begin
      ack_nxt = 1'b1;
      unique case (reg_addr)
        `LKE_OFF_CTRL: begin
          rdata_nxt = ctrl_r;
          if (reg_wr) begin
            ctrl_nxt = (reg_wdata & `LKE_CTL_MASK) | (ctrl_r & ~`LKE_CTL_MASK);
          end
        end
        `LKE_OFF_INBUF: begin
          rdata_nxt = inbuf_r;
          if (reg_wr) begin
            inbuf_nxt = reg_wdata;
          end
        end
        `LKE_OFF_OUTBUF: begin
          rdata_nxt = outbuf_r;
          if (reg_wr) begin
            outbuf_nxt = reg_wdata;
          end
        end
        `LKE_OFF_STATUS: begin
          rdata_nxt = stat_r;
          if (reg_wr) begin
            stat_nxt = reg_wdata;
          end
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    unique case (io_kind)
      lke_pkg::LKE_IO_RD: begin
        claim_nxt = 1'b1;
        iordy_nxt = 1'b1;
        if (io_port == `LKE_PORT_DATA) begin
          iord_nxt = outbuf_r[7:0];
          stat_nxt[`LKE_ST_OUTFULL] = 1'b0;
        end else begin
          iord_nxt = stat_r[7:0];
        end
      end
      lke_pkg::LKE_IO_WR: begin
        claim_nxt = 1'b1;
        iordy_nxt = fifo_in_ready;
        if (fifo_in_ready) begin
          inbuf_nxt = {24'h00_0000, io_wdata};
          if (io_port == `LKE_PORT_DATA) begin
            stat_nxt[`LKE_ST_INFULL]  = 1'b1;
            stat_nxt[`LKE_ST_CMDDATA] = 1'b0;
          end else begin
            stat_nxt[`LKE_ST_INFULL]  = 1'b0;
            stat_nxt[`LKE_ST_CMDDATA] = 1'b1;
            ctrl_nxt[`LKE_CTL_GATE_A20_SEQUENCE_FLAG]  = (io_wdata == `LKE_GA20_CMD);
          end
        end
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign out_full_fall = stat_r[`LKE_ST_OUTFULL] && !stat_nxt[`LKE_ST_OUTFULL];
  always_comb begin
    kbi_nxt = ctrl_r[`LKE_CTL_INTERRUPT_REQUEST_ENABLE] && stat_r[`LKE_ST_OUTFULL] && !stat_r[`LKE_ST_AUXFULL];
    msi_nxt = ctrl_r[`LKE_CTL_INTERRUPT_REQUEST_ENABLE] && stat_r[`LKE_ST_OUTFULL] && stat_r[`LKE_ST_AUXFULL];
    emi_nxt = (ctrl_r[`LKE_CTL_CP] && out_full_fall && ctrl_r[`LKE_CTL_EE])
      || (ctrl_r[`LKE_CTL_EXTERNAL_INTERRUPT_ENABLE] && (kb_s_r[1] || ms_s_r[1]));
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r   <= 32'h0000_0000;
      inbuf_r  <= 32'h0000_0000;
      outbuf_r <= 32'h0000_0000;
      stat_r   <= 32'h0000_0000;
      rdata_r  <= 32'h0000_0000;
      ack_r    <= 1'b0;
      iord_r   <= 8'h00;
      claim_r  <= 1'b0;
      iordy_r  <= 1'b0;
      kbi_r    <= 1'b0;
      msi_r    <= 1'b0;
      emi_r    <= 1'b0;
      kb_s_r   <= 2'h0;
      ms_s_r   <= 2'h0;
    end else begin
      ctrl_r   <= {ctrl_nxt[31:2], emi_nxt, ctrl_nxt[0]};
      inbuf_r  <= inbuf_nxt;
      outbuf_r <= outbuf_nxt;
      stat_r   <= stat_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
      iord_r   <= iord_nxt;
      claim_r  <= claim_nxt;
      iordy_r  <= iordy_nxt;
      kbi_r    <= kbi_nxt;
      msi_r    <= msi_nxt;
      emi_r    <= emi_nxt;
      kb_s_r   <= {kb_s_r[0], ext_kbd_irq};
      ms_s_r   <= {ms_s_r[0], ext_mouse_irq};
    end
  end

  assign reg_rdata           = rdata_r;
  assign reg_ack             = ack_r;
  assign io_claim            = claim_r;
  assign io_rdata            = iord_r;
  assign io_ready            = iordy_r;
  assign keyboard_interrupt  = kbi_r;
  assign mouse_interrupt     = msi_r;
  assign emulation_interrupt = emi_r;
endmodule
`default_nettype wire

// ---- tb/lke_props.sv ----
// Port assertions for lke_top.
// Assumes it is bound into lke_top, one clock, active-low reset.
`timescale 1ns/100ps
`default_nettype none
module lke_props #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Register port
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  // Legacy port and interrupts
  input wire logic        io_wr,
  input wire logic [7:0]  io_port,
  input wire logic        io_claim,
  input wire logic        io_ready,
  input wire logic        keyboard_interrupt,
  input wire logic        mouse_interrupt
);
  logic ee_r;
  logic ee_nxt;
  always_comb begin
    ee_nxt = ee_r;
    if (reg_sel && reg_wr && reg_addr == 12'h100) ee_nxt = reg_wdata[0];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ee_r <= 1'h0;
    else ee_r <= ee_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence in60_s;
    io_claim && !$past(io_wr) && $past(io_port) == 8'h60;
  endsequence
  sequence ctrl_rd_s;
    reg_ack && !$past(reg_wr) && $past(reg_addr) == 12'h100;
  endsequence
  reg_ack_a: assert property (reg_sel |=> reg_ack)
    else $error("register access not acknowledged");
  ack_idle_a: assert property (!reg_sel |=> !reg_ack && reg_rdata == 32'h0)
    else $error("ack or data without access");
  unmapped_rd_a: assert property (reg_sel && !(reg_addr inside {12'h100, 12'h104, 12'h108, 12'h10C})
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (ctrl_rd_s |-> reg_rdata[31:9] == 23'h0 && reg_rdata[0] == $past(ee_r))
    else $error("control read wrong");
  claim_gate_a: assert property (io_claim |-> $past(ee_r) && $past(io_port) inside {8'h60, 8'h64})
    else $error("claim while disabled or foreign port");
  ready_claim_a: assert property (io_ready |-> io_claim)
    else $error("ready without claim");
  read_done_a: assert property (io_claim && !$past(io_wr) |-> io_ready)
    else $error("read cycle not completed");
  irq_excl_a: assert property (!(keyboard_interrupt && mouse_interrupt))
    else $error("both interrupts high");
  in60_clear_a: assert property (in60_s |=> !keyboard_interrupt && !mouse_interrupt)
    else $error("interrupt after output read");
endmodule
bind lke_top lke_props #(.FIFO_DEPTH(FIFO_DEPTH)) props_u (
  .core_clk           (core_clk),
  .rstn               (rstn),
  .reg_sel            (reg_sel),
  .reg_wr             (reg_wr),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .reg_ack            (reg_ack),
  .io_wr              (io_wr),
  .io_port            (io_port),
  .io_claim           (io_claim),
  .io_ready           (io_ready),
  .keyboard_interrupt (keyboard_interrupt),
  .mouse_interrupt    (mouse_interrupt)
);
`default_nettype wire

// ---- tb/lke_host_model.sv ----
// Host model issuing legacy port cycles.
// Assumes same clock as lke_top.
`timescale 1ns/100ps
`default_nettype none
module lke_host_model (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Bench command
  input wire logic       req,
  input wire logic       req_wr,
  input wire logic [7:0] req_port,
  input wire logic [7:0] req_data,
  // Legacy cycle
  input wire logic       io_claim,
  input wire logic       io_ready,
  output logic           io_valid,
  output logic           io_wr,
  output logic     [7:0] io_port,
  output logic     [7:0] io_wdata
);
  logic wait_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {io_valid, io_wr, wait_r, io_port, io_wdata} <= 19'h0;
    end else if (!io_valid && req) begin
      {io_valid, io_wr, wait_r, io_port, io_wdata} <= {1'h1, req_wr, 1'h0, req_port, req_data};
    end else if (io_valid && (io_ready || (wait_r && !io_claim))) begin
      io_valid <= 1'h0;
      io_port  <= ~io_port;
      io_wdata <= ~io_wdata;
    end else if (io_valid) begin
      wait_r <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for lke_top.
// Assumes rtl/ on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "lke_defines.svh"
module testbench;
  logic        core_clk = 1'h0, rstn = 1'h0, reg_sel = 1'h0, reg_wr = 1'h0, req = 1'h0, req_wr = 1'h0;
  logic        inbyte_ready = 1'h0, ext_kbd_irq = 1'h0, ext_mouse_irq = 1'h0, emi_seen = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd, s;
  logic [7:0]  req_port = 8'h0, req_data = 8'h0, io_port, io_wdata, io_rdata, inbyte_data, b, q[$];
  logic        reg_ack, io_valid, io_wr, io_claim, io_ready, inbyte_valid, kbi, msi, emi;
  int          failures = 0, comparisons = 0, cyc = 0, ncl = 0, seed = 32'h1F776489;
  lke_host_model host_u (.core_clk, .rstn, .req, .req_wr, .req_port, .req_data, .io_claim, .io_ready,
    .io_valid, .io_wr, .io_port, .io_wdata);
  lke_top #(.FIFO_DEPTH(16)) dut_u (.core_clk, .rstn, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .io_valid, .io_wr, .io_port, .io_wdata, .io_claim, .io_rdata, .io_ready, .inbyte_valid,
    .inbyte_data, .inbyte_ready, .ext_kbd_irq, .ext_mouse_irq, .keyboard_interrupt(kbi),
    .mouse_interrupt(msi), .emulation_interrupt(emi));
  task results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [31:0] exp_flags(logic [7:0] p);
    return 32'h1 << ((p == `LKE_PORT_DATA) ? `LKE_ST_INFULL : `LKE_ST_CMDDATA);
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task rg(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    {reg_sel, reg_wr, reg_addr, reg_wdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    reg_sel <= 1'h0;
    @(negedge core_clk);
    rd = reg_rdata;
  endtask
  task io(logic w, logic [7:0] p, logic [7:0] d);
    @(posedge core_clk);
    {req, req_wr, req_port, req_data} <= {1'h1, w, p, d};
    @(posedge core_clk);
    req <= 1'h0;
    do @(negedge core_clk); while (io_valid);
  endtask
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (io_claim === 1'h1) ncl++;
    if (emi === 1'h1) emi_seen = 1'h1;
    if (inbyte_valid === 1'h1 && inbyte_ready) chk("fifo byte", q.pop_front(), inbyte_data);
    if (cyc == 5000) begin
      failures++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'h1;
    rg(0, 12'h100, 0);
    chk("ctrl reset", 0, rd);
    rg(0, 12'h1F0, 0);
    chk("unmapped", 0, rd);
    io(1, 8'h60, 8'h5A);
    chk("claims", 0, ncl);
    rg(1, 12'h100, 32'hFFFF_FFFF);
    rg(0, 12'h100, 0);
    chk("ctrl mask", `LKE_CTL_MASK, rd);
    rg(1, 12'h100, 32'h1);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      rg(1, 12'h108, {24'h0, b});
      rg(1, 12'h10C, 32'h1);
      rg(0, 12'h108, 0);
      chk("outbuf", {24'h0, b}, rd);
      io(0, 8'h60, 0);
      chk("in60 data", b, io_rdata);
      rg(0, 12'h10C, 0);
      chk("out_full", 0, rd[0]);
      b = 8'($random(seed));
      q.push_back(b);
      io(1, 8'h60, b);
      rg(0, 12'h104, 0);
      chk("inbuf", b, rd[7:0]);
      rg(0, 12'h10C, 0);
      chk("st60", exp_flags(8'h60), rd & 32'hA);
      b = i[0] ? 8'hD1 : 8'($random(seed));
      q.push_back(b);
      io(1, 8'h64, b);
      rg(0, 12'h10C, 0);
      chk("st64", exp_flags(8'h64), rd & 32'hA);
      rg(0, 12'h100, 0);
      chk("ga20", b == 8'hD1, rd[5]);
      rg(0, 12'h10C, 0);
      s = rd;
      io(0, 8'h64, 0);
      chk("in64", s[7:0], io_rdata);
      rg(0, 12'h10C, 0);
      chk("st kept", s, rd);
    end
    repeat (9) begin
      b = 8'($random(seed));
      q.push_back(b);
      @(posedge core_clk);
      {req, req_wr, req_port, req_data} <= {1'h1, 1'h1, 8'h60, b};
      @(posedge core_clk);
      req <= 1'h0;
      repeat (6) @(negedge core_clk);
    end
    chk("stalled", 1, io_valid);
    @(posedge core_clk);
    inbyte_ready <= 1'h1;
    repeat (40) @(negedge core_clk);
    chk("drained", 0, {q.size() != 0, inbyte_valid, io_valid});
    rg(1, 12'h100, 32'h9);
    for (int a = 0; a < 2; a++) begin
      rg(1, 12'h10C, a ? 32'h21 : 32'h1);
      repeat (3) @(negedge core_clk);
      chk("kbd irq", !a, kbi);
      chk("mouse irq", a, msi);
    end
    rg(1, 12'h100, 32'hD);
    rg(1, 12'h10C, 32'h1);
    emi_seen = 1'h0;
    io(0, 8'h60, 0);
    repeat (3) @(negedge core_clk);
    chk("char pend", 1, emi_seen);
    chk("kbd irq off", 0, kbi);
    rg(1, 12'h100, 32'h10);
    @(posedge core_clk);
    ext_kbd_irq <= 1'h1;
    repeat (6) @(negedge core_clk);
    chk("ext kbd irq", 1, emi);
    @(posedge core_clk);
    {ext_kbd_irq, ext_mouse_irq} <= 2'h1;
    repeat (6) @(negedge core_clk);
    chk("ext mouse irq", 1, emi);
    results;
  end
endmodule
`default_nettype wire
